/* File: mpr_board.sv */
// Board-side model that supplies the asynchronous input and synthesized clocks.
module mpr_board (
  input  wire  run,
  output logic input_clock,
  output logic synth_clock
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // Clock sources
  // ----------------------------------------------------------------
  // static until powered
  initial begin
    input_clock = 1'b0;
    synth_clock = 1'b0;
  end
  // The synth period is unrelated to the system clock, so its sampling phase drifts; the input period is 40 system clock cycles.
  always #23 if (run) synth_clock = ~synth_clock;
  always #200 if (run) input_clock = ~input_clock;
endmodule

/* File: mpr_defs.vh */
// Constants for the mode pin and output routing block.
`ifndef MPR_DEFS_VH
`define MPR_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define MPR_OFS_GLOBAL     8'h00
`define MPR_OFS_MODAL0     8'h04
`define MPR_OFS_MODAL3     8'h10
`define MPR_OFS_RATIO0     8'h14
`define MPR_OFS_RATIO3     8'h20
`define MPR_OFS_STATUS     8'h24
`define MPR_OFS_EFF_RATIO  8'h28

// ----------------------------------------------------------------
// Global register fields
// ----------------------------------------------------------------
`define MPR_GL_LOCKCFG     0
`define MPR_GL_UNLOCK_EN   1
`define MPR_GL_FN_LO       2
`define MPR_GL_FN_HI       4
`define MPR_GLOBAL_RST     5'h00

// ----------------------------------------------------------------
// Modal register fields
// ----------------------------------------------------------------
`define MPR_MD_SHIFT_LO    0
`define MPR_MD_SHIFT_HI    1
`define MPR_MD_AUX_LO      2
`define MPR_MD_AUX_HI      3
`define MPR_MD_LOCKIDX_LO  4
`define MPR_MD_LOCKIDX_HI  5
`define MPR_MD_FRACN       6
`define MPR_MODAL_RST      7'h00
`define MPR_RATIO_RST      32'h00000000

// ----------------------------------------------------------------
// Encodings
// ----------------------------------------------------------------
`define MPR_AUX_REF        2'h0
`define MPR_AUX_INCLK      2'h1
`define MPR_AUX_SYNTH      2'h2
`define MPR_AUX_LOCK       2'h3
`define MPR_FN_DIS_MAIN    3'h0
`define MPR_FN_DIS_AUX     3'h1
`define MPR_FN_DIS_BOTH    3'h2
`define MPR_FN_RMOD        3'h3
`define MPR_FN_FORCE_MAN   3'h4
`define MPR_FN_RSVD        3'h5
`define MPR_FN_SRC_OVR     3'h6
`define MPR_FN_AUX_SYNTH   3'h7

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define MPR_CLK_PERIOD_NS  10
`define MPR_LOCK_TIME_NS   100000
`define MPR_CLKIN_GAP      16'h1000
`define MPR_DRIFT_HI       20'd13
`define MPR_DRIFT_LO       20'd7
`define MPR_DRIFT_DIV      20'd10
`define MPR_STEP_SHIFT     3

`endif

/* File: mpr_routing.v */
// Mode pin decoding, output routing and lock control of the clock synthesizer.
//
// Added by the designer: the Wishbone slave port and the address map.
`include "mpr_defs.vh"

module mpr_routing #(
  parameter LOCK_TIME_NS = `MPR_LOCK_TIME_NS
) (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire        wb_ack_o,
  input  wire        mode_select_lo,
  input  wire        mode_select_hi,
  input  wire        multipurpose_pin,
  input  wire        input_clock,
  input  wire        synth_clock,
  input  wire        ref_clock_fault,
  output wire        main_clk_out,
  output wire        main_clk_oe,
  output wire        aux_out,
  output wire        aux_oe,
  output wire [31:0] effective_ratio,
  output wire [1:0]  active_ratio_index,
  output wire        fracn_dynamic,
  output wire        pll_locked
);

  localparam [31:0] LOCK_CYCLES = (LOCK_TIME_NS + `MPR_CLK_PERIOD_NS - 1) / `MPR_CLK_PERIOD_NS;
  localparam [23:0] LOCK_LAST   = LOCK_CYCLES[23:0] - 24'h000001;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  wire [5:0] pin_raw = {ref_clock_fault, synth_clock, input_clock,
                        multipurpose_pin, mode_select_hi, mode_select_lo};
  reg  [5:0] sync1_ff;
  reg  [5:0] sync2_ff;
  reg  [5:0] sync3_ff;

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_sync
      always @(posedge clk) begin
        if (sys_rst) begin
          sync1_ff[gi] <= 1'b0;
          sync2_ff[gi] <= 1'b0;
          sync3_ff[gi] <= 1'b0;
        end else begin
          sync1_ff[gi] <= pin_raw[gi];
          sync2_ff[gi] <= sync1_ff[gi];
          sync3_ff[gi] <= sync2_ff[gi];
        end
      end
    end
  endgenerate

  wire [1:0] mode      = sync2_ff[1:0];
  wire       mp        = sync2_ff[2];
  wire       inclk_lvl = sync2_ff[3];
  wire       synth_lvl = sync2_ff[4];
  wire       ref_fault = sync2_ff[5];

  // ----------------------------------------------------------------
  // Configuration storage and Wishbone slave
  // ----------------------------------------------------------------
  function [31:0] wb_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0]  sel;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        wb_merge[k*8 +: 8] = sel[k] ? new_val[k*8 +: 8] : old_val[k*8 +: 8];
      end
    end
  endfunction

  reg  [4:0]  global_ff;
  reg  [6:0]  modal_ff [0:3];
  reg  [31:0] ratio_ff [0:3];
  reg         ack_ff;
  reg  [31:0] rdat_ff;
  reg  [31:0] nxt_rdat;
  wire        wb_req = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire [1:0]  wsel   = wb_adr_i[3:2] - 2'h1;
  wire [31:0] gl_mrg = wb_merge({27'h0000000, global_ff}, wb_dat_i, wb_sel_i);
  wire [31:0] md_mrg = wb_merge({25'h0000000, modal_ff[wsel]}, wb_dat_i, wb_sel_i);
  wire [31:0] status_word;
  integer     i;

  always @* begin
    nxt_rdat = 32'h00000000;
    if (wb_adr_i == `MPR_OFS_GLOBAL) begin
      nxt_rdat = {27'h0000000, global_ff};
    end else if (wb_adr_i >= `MPR_OFS_MODAL0 && wb_adr_i <= `MPR_OFS_MODAL3) begin
      nxt_rdat = {25'h0000000, modal_ff[wsel]};
    end else if (wb_adr_i >= `MPR_OFS_RATIO0 && wb_adr_i <= `MPR_OFS_RATIO3) begin
      nxt_rdat = ratio_ff[wb_adr_i[3:2] - 2'h1];
    end else if (wb_adr_i == `MPR_OFS_STATUS) begin
      nxt_rdat = status_word;
    end else if (wb_adr_i == `MPR_OFS_EFF_RATIO) begin
      nxt_rdat = effective_ratio;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      ack_ff    <= 1'b0;
      rdat_ff   <= 32'h00000000;
      global_ff <= `MPR_GLOBAL_RST;
      for (i = 0; i < 4; i = i + 1) begin
        modal_ff[i] <= `MPR_MODAL_RST;
        ratio_ff[i] <= `MPR_RATIO_RST;
      end
    end else begin
      ack_ff <= wb_req;
      if (wb_req & ~wb_we_i) begin
        rdat_ff <= nxt_rdat;
      end
      if (wb_req & wb_we_i) begin
        if (wb_adr_i == `MPR_OFS_GLOBAL) begin
          global_ff <= gl_mrg[4:0];
        end else if (wb_adr_i >= `MPR_OFS_MODAL0 && wb_adr_i <= `MPR_OFS_MODAL3) begin
          modal_ff[wsel] <= md_mrg[6:0];
        end else if (wb_adr_i >= `MPR_OFS_RATIO0 && wb_adr_i <= `MPR_OFS_RATIO3) begin
          ratio_ff[wsel] <= wb_merge(ratio_ff[wsel], wb_dat_i, wb_sel_i);
        end
      end
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

  // ----------------------------------------------------------------
  // Modal set selection and multipurpose pin decode
  // ----------------------------------------------------------------
  // mode pins pick set
  wire [6:0] modal     = modal_ff[mode];
  wire [1:0] shift_sel = modal[`MPR_MD_SHIFT_HI:`MPR_MD_SHIFT_LO];
  wire [1:0] aux_sel   = modal[`MPR_MD_AUX_HI:`MPR_MD_AUX_LO];
  wire [1:0] lock_idx  = modal[`MPR_MD_LOCKIDX_HI:`MPR_MD_LOCKIDX_LO];
  wire       man_src   = modal[`MPR_MD_FRACN];
  wire       lock_cfg  = global_ff[`MPR_GL_LOCKCFG];
  wire       unl_en    = global_ff[`MPR_GL_UNLOCK_EN];
  wire [2:0] mp_fn     = global_ff[`MPR_GL_FN_HI:`MPR_GL_FN_LO];

  wire main_dis = mp & (mp_fn == `MPR_FN_DIS_MAIN || mp_fn == `MPR_FN_DIS_BOTH);
  wire aux_dis  = mp & (mp_fn == `MPR_FN_DIS_AUX || mp_fn == `MPR_FN_DIS_BOTH);
  wire rmod_en  = mp & (mp_fn == `MPR_FN_RMOD);
  wire auto_en  = (lock_idx != mode);
  // pin hands source to manual bit
  wire auto_act = auto_en & ~(mp & (mp_fn == `MPR_FN_FORCE_MAN));
  wire man_eff  = (mp_fn == `MPR_FN_SRC_OVR) ? mp : man_src;
  reg  inclk_present_ff;
  wire dyn_src  = auto_act ? inclk_present_ff : man_eff;
  wire [1:0] ratio_idx = dyn_src ? lock_idx : mode;

  // ----------------------------------------------------------------
  // Effective ratio
  // ----------------------------------------------------------------
  reg [31:0] eff_ratio_ff;
  reg        dyn_ff;
  reg [1:0]  ratio_idx_ff;
  always @(posedge clk) begin
    if (sys_rst) begin
      eff_ratio_ff <= 32'h00000000;
      dyn_ff       <= 1'b0;
      ratio_idx_ff <= 2'h0;
    end else begin
      dyn_ff       <= dyn_src;
      ratio_idx_ff <= ratio_idx;
      if (rmod_en) begin
        eff_ratio_ff <= ratio_ff[ratio_idx] >> ({1'b0, shift_sel} + 3'h1);
      end else begin
        eff_ratio_ff <= ratio_ff[ratio_idx];
      end
    end
  end

  assign effective_ratio    = eff_ratio_ff;
  assign fracn_dynamic      = dyn_ff;
  assign active_ratio_index = ratio_idx_ff;

  // ----------------------------------------------------------------
  // Input clock monitor
  // ----------------------------------------------------------------
  // Periods are measured in system clock cycles, so only inputs well below
  // half the system clock can be judged.
  reg  [15:0] per_cnt_ff;
  reg  [15:0] prev_per_ff;
  reg  [15:0] start_per_ff;
  reg         inclk_fault_ff;
  wire        inclk_rise = inclk_lvl & ~sync3_ff[3];
  wire [19:0] per_x10    = {4'h0, per_cnt_ff} * `MPR_DRIFT_DIV;
  wire [19:0] start_ext  = {4'h0, start_per_ff};
  wire [15:0] step_diff  = (per_cnt_ff > prev_per_ff) ? per_cnt_ff - prev_per_ff
                                                      : prev_per_ff - per_cnt_ff;
  always @(posedge clk) begin
    if (sys_rst) begin
      per_cnt_ff       <= 16'h0000;
      prev_per_ff      <= 16'h0000;
      start_per_ff     <= 16'h0000;
      inclk_present_ff <= 1'b0;
      inclk_fault_ff   <= 1'b0;
    end else begin
      inclk_fault_ff <= 1'b0;
      if (inclk_rise) begin
        per_cnt_ff  <= 16'h0001;
        prev_per_ff <= per_cnt_ff;
        if (!inclk_present_ff) begin
          inclk_present_ff <= 1'b1;
          start_per_ff     <= 16'h0000;
        end else if (start_per_ff == 16'h0000) begin
          start_per_ff <= per_cnt_ff;
        end else begin
          inclk_fault_ff <= (per_x10 > start_ext * `MPR_DRIFT_HI) |
                            (per_x10 < start_ext * `MPR_DRIFT_LO) |
                            (step_diff > (prev_per_ff >> `MPR_STEP_SHIFT));
        end
      end else if (per_cnt_ff == `MPR_CLKIN_GAP) begin
        inclk_fault_ff   <= inclk_present_ff;
        inclk_present_ff <= 1'b0;
      end else begin
        per_cnt_ff <= per_cnt_ff + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Lock control
  // ----------------------------------------------------------------
  reg  [23:0] lock_cnt_ff;
  reg         locked_ff;
  reg         dyn_prev_ff;
  wire mode_chg = (sync2_ff[1:0] != sync3_ff[1:0]);
  wire mp_chg   = (sync2_ff[2] != sync3_ff[2]) &
                  (mp_fn == `MPR_FN_RMOD || mp_fn == `MPR_FN_FORCE_MAN ||
                   mp_fn == `MPR_FN_RSVD || mp_fn == `MPR_FN_SRC_OVR);
  wire unlock_evt = mode_chg | mp_chg | ref_fault | (inclk_fault_ff & dyn_src) |
                    (dyn_src != dyn_prev_ff);

  always @(posedge clk) begin
    if (sys_rst) begin
      lock_cnt_ff <= 24'h000000;
      locked_ff   <= 1'b0;
      dyn_prev_ff <= 1'b0;
    end else begin
      dyn_prev_ff <= dyn_src;
      if (unlock_evt) begin
        lock_cnt_ff <= 24'h000000;
        locked_ff   <= 1'b0;
      end else if (lock_cnt_ff == LOCK_LAST) begin
        locked_ff <= 1'b1;
      end else begin
        lock_cnt_ff <= lock_cnt_ff + 24'h000001;
      end
    end
  end

  assign pll_locked = locked_ff;

  // ----------------------------------------------------------------
  // Main clock output
  // ----------------------------------------------------------------
  reg main_run_ff;
  reg main_drv_ff;
  reg main_out_ff;
  always @(posedge clk) begin
    if (sys_rst) begin
      main_run_ff <= 1'b0;
      main_drv_ff <= 1'b0;
      main_out_ff <= 1'b0;
    end else begin
      // gates change only in the low phase
      if (!synth_lvl) begin
        main_run_ff <= locked_ff | unl_en;
        main_drv_ff <= ~main_dis;
      end
      main_out_ff <= main_run_ff & synth_lvl;
    end
  end

  assign main_clk_out = main_out_ff;
  assign main_clk_oe  = main_drv_ff;

  // ----------------------------------------------------------------
  // Auxiliary output
  // ----------------------------------------------------------------
  reg  [1:0] aux_src_ff;
  reg        aux_drv_ff;
  reg        aux_out_ff;
  reg        aux_oe_ff;
  reg        ref_tgl_ff;
  wire [1:0] aux_req = (mp & (mp_fn == `MPR_FN_AUX_SYNTH)) ? `MPR_AUX_SYNTH : aux_sel;

  function aux_level;
    input [1:0] src;
    input       ref_l;
    input       in_l;
    input       syn_l;
    begin
      if (src == `MPR_AUX_REF) begin
        aux_level = ref_l;
      end else if (src == `MPR_AUX_INCLK) begin
        aux_level = in_l;
      end else begin
        aux_level = syn_l;
      end
    end
  endfunction

  wire cur_lvl = aux_level(aux_src_ff, ref_tgl_ff, inclk_lvl, synth_lvl);
  wire req_lvl = aux_level(aux_req, ref_tgl_ff, inclk_lvl, synth_lvl);
  // switching via 01 or 11 is immediate
  wire fast_sw = (aux_req == `MPR_AUX_INCLK) | (aux_req == `MPR_AUX_LOCK) |
                 (aux_src_ff == `MPR_AUX_INCLK) | (aux_src_ff == `MPR_AUX_LOCK);

  // aux synth copy is phase aligned with the main output
  always @(posedge clk) begin
    if (sys_rst) begin
      ref_tgl_ff <= 1'b0;
      aux_src_ff <= `MPR_AUX_REF;
      aux_drv_ff <= 1'b0;
      aux_out_ff <= 1'b0;
      aux_oe_ff  <= 1'b0;
    end else begin
      ref_tgl_ff <= ~ref_tgl_ff;
      // 00 and 10 swap only while both are low
      if (fast_sw | (~cur_lvl & ~req_lvl)) begin
        aux_src_ff <= aux_req;
      end
      if (fast_sw | ~cur_lvl) begin
        aux_drv_ff <= ~aux_dis;
      end
      if (aux_src_ff == `MPR_AUX_LOCK) begin
        // push-pull high or open-drain low when unlocked
        aux_out_ff <= ~lock_cfg & ~locked_ff;
        aux_oe_ff  <= aux_drv_ff & (~lock_cfg | ~locked_ff);
      end else begin
        aux_out_ff <= aux_drv_ff & cur_lvl;
        aux_oe_ff  <= aux_drv_ff;
      end
    end
  end

  assign aux_out = aux_out_ff;
  assign aux_oe  = aux_oe_ff;

  assign status_word = {24'h000000, aux_src_ff, mode, inclk_present_ff, rmod_en,
                        dyn_ff, locked_ff};

endmodule

/* File: mpr_routing_bench.sv */
// Self-checking bench for the mode pin and output routing block.
module mpr_routing_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        wb_cyc = 1'b0;
  logic        wb_stb = 1'b0;
  logic        wb_we = 1'b0;
  logic [7:0]  wb_adr = 8'h00;
  logic [31:0] wb_dat = 32'h0;
  logic        ms_lo = 1'b0;
  logic        ms_hi = 1'b0;
  logic        mp_pin = 1'b0;
  logic        ref_fault = 1'b0;
  logic        run = 1'b0;
  logic [31:0] q;
  wire  [31:0] wb_dat_o, eff;
  wire         wb_ack_o, in_clk, syn_clk, main_out, main_oe, aux_out, aux_oe, locked;
  wire         dyn;
  wire  [1:0]  ridx;
  logic        seen;
  int          error_cnt = 0;
  int          checks_done = 0;
  int          cyc_cnt = 0;

  mpr_routing #(.LOCK_TIME_NS(100)) i_mpr_routing (
    .clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .mode_select_lo(ms_lo), .mode_select_hi(ms_hi),
    .multipurpose_pin(mp_pin), .input_clock(in_clk), .synth_clock(syn_clk),
    .ref_clock_fault(ref_fault), .main_clk_out(main_out), .main_clk_oe(main_oe),
    .aux_out(aux_out), .aux_oe(aux_oe), .effective_ratio(eff), .active_ratio_index(ridx),
    .fracn_dynamic(dyn), .pll_locked(locked));
  mpr_board i_mpr_board (.run(run), .input_clock(in_clk), .synth_clock(syn_clk));

  always #5 clk = ~clk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] rv(input int n);
    return 32'h01234560 + 32'(n);
  endfunction
  task finish_test();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    // The take edge is the first one, so a registered ack is seen on the second.
    chk("wb_ack_lat", 32'h2, 32'(n));
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0);
  endtask
  task pins(input logic [1:0] m, input logic p);
    @(posedge clk);
    {ms_hi, ms_lo} <= m;
    mp_pin <= p;
  endtask
  task settle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task wait_lock();
    int n;
    n = 0;
    settle(6);
    while (locked !== 1'b1 && n < 60) begin
      @(posedge clk);
      n++;
    end
    chk("pll_locked", 32'h1, locked);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_init();
    for (int i = 1; i <= 6; i++)
      pins({1'b0, i[0]}, 1'b0);
    wait_lock();
    $display("test init done");
  endtask
  task t_regs();
    rd(8'h00);
    chk("global_rst", 32'h0, q);
    wr(8'h08, 32'hffffffff);
    rd(8'h08);
    chk("modal_width", 32'h7f, q);
    rd(8'h3c);
    chk("unmapped", 32'h0, q);
    for (int n = 0; n < 4; n++) begin
      wr(8'h04 + 8'(4 * n), 32'(n) << 4);
      wr(8'h14 + 8'(4 * n), rv(n));
      rd(8'h14 + 8'(4 * n));
      chk("ratio", rv(n), q);
    end
    $display("test regs done");
  endtask
  task t_mode();
    for (int m = 0; m < 4; m++) begin
      pins(2'(m), 1'b0);
      wait_lock();
      chk("eff_ratio", rv(m), eff);
      rd(8'h24);
      chk("mode_field", 32'(m), q[5:4]);
    end
    pins(2'h0, 1'b0);
    wait_lock();
    $display("test mode done");
  endtask
  task t_rmod();
    wr(8'h00, 32'h0c);
    for (int s = 0; s < 4; s++) begin
      wr(8'h04, 32'(s));
      pins(2'h0, 1'b1);
      wait_lock();
      chk("eff_shift", rv(0) >> (s + 1), eff);
      pins(2'h0, 1'b0);
      wait_lock();
      chk("eff_plain", rv(0), eff);
    end
    $display("test rmod done");
  endtask
  task t_dis();
    wr(8'h04, 32'h0);
    for (int f = 0; f < 3; f++) begin
      wr(8'h00, 32'(f) << 2);
      pins(2'h0, 1'b1);
      settle(8);
      chk("main_oe_pin", f == 1, main_oe);
      chk("aux_oe_pin", f == 0, aux_oe);
      chk("eff_no_mod", rv(0), eff);
      pins(2'h0, 1'b0);
      settle(8);
      chk("main_oe_on", 32'h1, main_oe);
      chk("aux_oe_on", 32'h1, aux_oe);
    end
    $display("test disable done");
  endtask
  task t_aux();
    wr(8'h04, 32'h0c);
    wr(8'h00, 32'h0);
    wait_lock();
    settle(4);
    chk("ind_locked", 32'h0, aux_out);
    chk("ind_oe", 32'h1, aux_oe);
    @(posedge clk);
    ref_fault <= 1'b1;
    settle(10);
    chk("ind_unlocked", 32'h1, aux_out);
    repeat (8) begin
      @(posedge clk);
      chk("main_low", 32'h0, main_out);
    end
    wr(8'h00, 32'h2);
    settle(6);
    seen = 1'b0;
    repeat (8) begin
      @(posedge clk);
      seen = seen | main_out;
    end
    chk("main_unl_run", 32'h1, seen);
    wr(8'h00, 32'h1);
    settle(4);
    chk("od_unlocked", 32'h0, aux_out);
    chk("od_drive", 32'h1, aux_oe);
    @(posedge clk);
    ref_fault <= 1'b0;
    wait_lock();
    settle(4);
    chk("od_locked_hiz", 32'h0, aux_oe);
    wr(8'h00, 32'h1d);
    pins(2'h0, 1'b1);
    settle(8);
    rd(8'h24);
    chk("aux_forced", 32'h2, q[7:6]);
    chk("aux_clk_oe", 32'h1, aux_oe);
    pins(2'h0, 1'b0);
    settle(8);
    rd(8'h24);
    chk("aux_follow", 32'h3, q[7:6]);
    $display("test aux done");
  endtask
  task t_src();
    // Set 0 points its lock index at ratio 1, so automatic selection is on.
    wr(8'h00, 32'h10);
    wr(8'h04, 32'h10);
    wait_lock();
    chk("auto_dyn", 32'h1, dyn);
    chk("auto_idx", 32'h1, ridx);
    chk("auto_ratio", rv(1), eff);
    pins(2'h0, 1'b1);
    wait_lock();
    chk("force_man", 32'h0, dyn);
    chk("force_idx", 32'h0, ridx);
    pins(2'h0, 1'b0);
    wr(8'h00, 32'h18);
    wait_lock();
    chk("ovr_ignored", 32'h1, dyn);
    wr(8'h04, 32'h40);
    wait_lock();
    chk("ovr_low", 32'h0, dyn);
    pins(2'h0, 1'b1);
    wait_lock();
    chk("ovr_high", 32'h1, dyn);
    chk("ovr_ratio", rv(0), eff);
    pins(2'h0, 1'b0);
    $display("test source done");
  endtask

  // ----------------------------------------------------------------
  // Sequence and timeout
  // ----------------------------------------------------------------
  // The ceiling is more than twenty times the expected run, so only a hang reaches it.
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      finish_test();
    end
  end
  initial begin
    settle(12);
    sys_rst <= 1'b0;
    run <= 1'b1;
    t_init();
    t_regs();
    t_mode();
    t_rmod();
    t_dis();
    t_aux();
    t_src();
    finish_test();
  end
endmodule

/* File: mpr_routing_props.sv */
// Concurrent checks on the bus handshake and lock behaviour of the routing block.
module mpr_routing_props #(
  parameter LOCK_TIME_NS = 100000
) (
  input wire        clk,
  input wire        sys_rst,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_ack_o,
  input wire [31:0] wb_dat_o,
  input wire        mode_select_lo,
  input wire        mode_select_hi,
  input wire        ref_clock_fault,
  input wire        pll_locked
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF_LOCK = LOCK_TIME_NS / 20;
  logic [15:0] unl_ff;
  logic [15:0] nxt_unl;

  // ----------------------------------------------------------------
  // Unlocked spell counter
  // ----------------------------------------------------------------
  // The count saturates so a long unlocked spell cannot wrap.
  always @* begin
    nxt_unl = unl_ff;
    if (pll_locked)
      nxt_unl = 16'h0;
    else if (unl_ff != 16'hffff)
      nxt_unl = unl_ff + 16'h1;
  end
  always @(posedge clk) begin
    if (sys_rst)
      unl_ff <= 16'h0;
    else
      unl_ff <= nxt_unl;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_drop_soon;
    ##[1:4] !pll_locked;
  endsequence

  a_ack_answer: assert property (s_req |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_dat_hold: assert property ($fell(wb_ack_o) |-> $stable(wb_dat_o))
    else $error("read data moved after ack");
  a_mode_unlock: assert property (
    $changed({mode_select_hi, mode_select_lo}) |-> s_drop_soon)
    else $error("lock kept over mode change");
  a_fault_unlock: assert property (ref_clock_fault |-> s_drop_soon)
    else $error("lock kept over reference fault");
  a_lock_wait: assert property ($rose(pll_locked) |-> int'(unl_ff) >= HALF_LOCK)
    else $error("lock came too early");
  a_unlock_hold: assert property ($fell(pll_locked) |=> !pll_locked [*4])
    else $error("relock too soon");
endmodule

bind mpr_routing mpr_routing_props #(.LOCK_TIME_NS(LOCK_TIME_NS)) i_mpr_routing_props (
  .clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .mode_select_lo(mode_select_lo),
  .mode_select_hi(mode_select_hi), .ref_clock_fault(ref_clock_fault),
  .pll_locked(pll_locked));
